// ### rtl/bls_params.svh
// Constants for the byte-load / word-store unit
`ifndef BLS_PARAMS_SVH
`define BLS_PARAMS_SVH

// Pointer file slots
`define BLS_STACK_PTR_IDX 3'h6
`define BLS_FRAME_PTR_IDX 3'h7
`define BLS_PREG_RST 32'h0000_0000
`define BLS_MREG_RST 32'h0000_0000

// Post-modify steps in bytes
`define BLS_BYTE_STEP 32'h0000_0001
`define BLS_WORD_STEP 32'h0000_0004

// Immediate field widths
`define BLS_BYTE_OFS_W 15
`define BLS_SHORT_OFS_W 6
`define BLS_LONG_OFS_W 17
`define BLS_FRAME_OFS_W 8

// Word alignment mask on the low address bits
`define BLS_WORD_ALIGN_MASK 2'h3

// Address generator register bank select codes
`define BLS_ADDR_GEN_IDX 2'h0
`define BLS_ADDR_GEN_MOD 2'h1
`define BLS_ADDR_GEN_LEN 2'h2
`define BLS_ADDR_GEN_BASE 2'h3

`endif

// ### rtl/bls_pkg.sv
// Types shared by the byte-load / word-store unit
`default_nettype none

package bls_pkg;

  typedef enum logic [1:0] {
    OP_LDB = 2'b00,
    OP_STP = 2'b01,
    OP_STD = 2'b10
  } bls_op_t;

  typedef enum logic [3:0] {
    MD_IND   = 4'b0000,
    MD_INC   = 4'b0001,
    MD_DEC   = 4'b0010,
    MD_OFS   = 4'b0011,
    MD_PIDX  = 4'b0100,
    MD_FRAME = 4'b0101,
    MD_I_IND = 4'b0110,
    MD_I_INC = 4'b0111,
    MD_I_DEC = 4'b1000,
    MD_I_MOD = 4'b1001
  } bls_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } bls_state_t;

endpackage : bls_pkg

`default_nettype wire

// ### rtl/bls_agu_if.sv
// Request and result of the address generator
`default_nettype none

interface bls_agu_if;
  import bls_pkg::*;
  bls_op_t op;
  bls_mode_t mode;
  logic insn32;
  logic neg;
  logic same_ptr;
  logic [31:0] base;
  logic [31:0] step2;
  logic [31:0] ilen;
  logic [31:0] ibase;
  logic [16:0] imm;
  logic [31:0] ea;
  logic [31:0] upd_val;
  logic upd_en;
  logic misalign;

  modport req (
    output op, mode, insn32, neg, same_ptr, base, step2, ilen, ibase, imm,
    input ea, upd_val, upd_en, misalign
  );
  modport agu (
    input op, mode, insn32, neg, same_ptr, base, step2, ilen, ibase, imm,
    output ea, upd_val, upd_en, misalign
  );
endinterface : bls_agu_if

`default_nettype wire

// ### rtl/bls_agu.sv
// Address generator: effective address, pointer update, circular wrap
`include "bls_params.svh"
`default_nettype none

module bls_agu
  import bls_pkg::*;
(
  // Request and result
  bls_agu_if.agu a
);

  function automatic logic [31:0] offset_of(input bls_op_t op, input bls_mode_t md,
                                            input logic wide, input logic [16:0] imm);
    logic [31:0] ofs;
    ofs = 32'h0;
    if (op == OP_LDB) begin
      ofs = {17'h0, imm[`BLS_BYTE_OFS_W-1:0]};
    end else if (md == MD_FRAME) begin
      ofs = {24'h0, imm[`BLS_FRAME_OFS_W-1:2], 2'h0};
    end else if (wide) begin
      ofs = {15'h0, imm[`BLS_LONG_OFS_W-1:2], 2'h0};
    end else begin
      ofs = {26'h0, imm[`BLS_SHORT_OFS_W-1:2], 2'h0};
    end
    return ofs;
  endfunction

  logic [31:0] ofs;
  logic [31:0] step;
  logic [31:0] raw;
  logic is_ireg;
  logic going_down;

  always_comb begin
    ofs = offset_of(a.op, a.mode, a.insn32, a.imm);
    step = (a.op == OP_LDB) ? `BLS_BYTE_STEP : `BLS_WORD_STEP;
    a.ea = a.base;
    raw = a.base;
    is_ireg = 1'b0;
    going_down = 1'b0;
    a.upd_en = 1'b0;
    case (a.mode)
      MD_IND: a.ea = a.base;
      MD_INC: begin
        raw = a.base + step;
        a.upd_en = 1'b1;
      end
      MD_DEC: begin
        raw = a.base - step;
        going_down = 1'b1;
        a.upd_en = 1'b1;
      end
      MD_OFS: a.ea = a.neg ? a.base - ofs : a.base + ofs;
      MD_PIDX: begin
        raw = a.base + a.step2;
        a.upd_en = !a.same_ptr;
      end
      MD_FRAME: a.ea = a.base - ofs;
      MD_I_IND: is_ireg = 1'b1;
      MD_I_INC: begin
        raw = a.base + `BLS_WORD_STEP;
        is_ireg = 1'b1;
        a.upd_en = 1'b1;
      end
      MD_I_DEC: begin
        raw = a.base - `BLS_WORD_STEP;
        is_ireg = 1'b1;
        going_down = 1'b1;
        a.upd_en = 1'b1;
      end
      MD_I_MOD: begin
        raw = a.base + a.step2;
        is_ireg = 1'b1;
        going_down = a.step2[31];
        a.upd_en = 1'b1;
      end
      default: a.ea = a.base;
    endcase
    a.upd_val = raw;
    // Wrap inside the buffer when a length is set
    if (is_ireg && a.ilen != 32'h0) begin
      if (going_down && raw < a.ibase) begin
        a.upd_val = raw + a.ilen;
      end else if (!going_down && raw >= a.ibase + a.ilen) begin
        a.upd_val = raw - a.ilen;
      end
    end
    a.misalign = (a.op != OP_LDB) && ((a.ea[1:0] & `BLS_WORD_ALIGN_MASK) != 2'h0);
    if (a.misalign) begin
      a.upd_en = 1'b0;
    end
  end

endmodule : bls_agu

`default_nettype wire

// ### rtl/bls_lsu.sv
// Byte-load / word-store execution unit with pointer and address generator registers
//
// Notes on behaviour
// - Signed byte load copies bit 7 upward
// - Unsigned byte load clears bits 31-8
// - Byte loads never raise alignment faults
// - Byte post-modify steps pointer by one
// - Byte offset 15 bits, pointer unchanged
// - Wide forms refused when issued in parallel
// - Pointer store writes full 32-bit pointer
// - Word stores fault unless address aligned
// - Word post-modify steps pointer by four
// - Short store offset 0 to 60
// - Long store offset up to 131068, signed
// - Frame store subtracts 0 to 252
// - Data store via pointer, index or frame
// - Index stores: plain, inc, dec, modify
// - Index updates wrap when length nonzero
// - Index, length, base not reset
// - Post-index adds second pointer afterwards
// - Same pointer twice: no update
// - Pointer set: six, stack, frame
`include "bls_params.svh"
`default_nettype none

module bls_lsu
  import bls_pkg::*;
#(
  parameter int NUM_PREG = 8,
  parameter int NUM_ADDR_GEN = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction issue
  input wire logic op_valid,
  input wire bls_op_t op_code,
  input wire bls_mode_t op_mode,
  input wire logic op_insn32,
  input wire logic op_parallel,
  input wire logic op_sign,
  input wire logic op_neg,
  input wire logic [2:0] op_dreg,
  input wire logic [2:0] op_preg,
  input wire logic [2:0] op_preg2,
  input wire logic [2:0] op_src,
  input wire logic [1:0] op_ireg,
  input wire logic [1:0] op_mreg,
  input wire logic [16:0] op_imm,
  input wire logic [31:0] op_store_data,
  output logic op_ready_r,
  // Register file writes and readback
  input wire logic ptr_wr_en,
  input wire logic [2:0] ptr_wr_idx,
  input wire logic [31:0] ptr_wr_data,
  input wire logic addr_gen_wr_en,
  input wire logic [1:0] addr_gen_wr_sel,
  input wire logic [1:0] addr_gen_wr_idx,
  input wire logic [31:0] addr_gen_wr_data,
  input wire logic [2:0] ptr_rd_idx,
  output logic [31:0] ptr_rd_data_r,
  // Data memory
  output logic mem_req_r,
  output logic mem_we_r,
  output logic mem_byte_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  // Results and events
  output logic ld_wb_valid_r,
  output logic [2:0] ld_wb_idx_r,
  output logic [31:0] ld_wb_data_r,
  output logic misalign_exc_r,
  output logic par_refuse_r
);

  function automatic logic is_ireg_mode(input bls_mode_t md);
    return (md == MD_I_IND) || (md == MD_I_INC) || (md == MD_I_DEC) || (md == MD_I_MOD);
  endfunction

  // Six general pointers, then stack and frame pointers
  logic [31:0] p_r [NUM_PREG];
  logic [31:0] i_r [NUM_ADDR_GEN];
  logic [31:0] m_r [NUM_ADDR_GEN];
  logic [31:0] l_r [NUM_ADDR_GEN];
  logic [31:0] b_r [NUM_ADDR_GEN];
  bls_state_t state_r;
  bls_state_t state_nxt;
  logic ld_sign_r;

  logic accept;
  logic refuse;
  logic go;
  logic fault;
  logic upd_p;
  logic upd_i;
  logic [2:0] base_pidx;
  logic [31:0] src_data;

  bls_agu_if agu_bus ();

  bls_agu u_agu (
    .a(agu_bus.agu)
  );

  assign accept = op_valid && op_ready_r;
  assign refuse = accept && op_insn32 && op_parallel;
  assign go = accept && !refuse;
  assign fault = go && agu_bus.misalign;
  assign base_pidx = (op_mode == MD_FRAME) ? `BLS_FRAME_PTR_IDX : op_preg;
  assign upd_p = go && agu_bus.upd_en && !is_ireg_mode(op_mode);
  assign upd_i = go && agu_bus.upd_en && is_ireg_mode(op_mode);
  assign src_data = (op_code == OP_STP) ? p_r[op_src] : op_store_data;

  // Drive the address generator
  assign agu_bus.op = op_code;
  assign agu_bus.mode = op_mode;
  assign agu_bus.insn32 = op_insn32;
  assign agu_bus.neg = op_neg;
  assign agu_bus.same_ptr = (op_preg == op_preg2);
  assign agu_bus.base = is_ireg_mode(op_mode) ? i_r[op_ireg] : p_r[base_pidx];
  assign agu_bus.step2 = is_ireg_mode(op_mode) ? m_r[op_mreg] : p_r[op_preg2];
  assign agu_bus.ilen = l_r[op_ireg];
  assign agu_bus.ibase = b_r[op_ireg];
  assign agu_bus.imm = op_imm;

  // Pointer file; instruction update wins over a sequencer write
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int k = 0; k < NUM_PREG; k++) begin
        p_r[k] <= `BLS_PREG_RST;
      end
    end else begin
      if (ptr_wr_en) begin
        p_r[ptr_wr_idx] <= ptr_wr_data;
      end
      if (upd_p) begin
        p_r[op_preg] <= agu_bus.upd_val;
      end
    end
  end

  // Index, length and base hold whatever they had through reset
  always_ff @(posedge clock) begin
    if (addr_gen_wr_en && addr_gen_wr_sel == `BLS_ADDR_GEN_IDX) begin
      i_r[addr_gen_wr_idx] <= addr_gen_wr_data;
    end
    if (addr_gen_wr_en && addr_gen_wr_sel == `BLS_ADDR_GEN_LEN) begin
      l_r[addr_gen_wr_idx] <= addr_gen_wr_data;
    end
    if (addr_gen_wr_en && addr_gen_wr_sel == `BLS_ADDR_GEN_BASE) begin
      b_r[addr_gen_wr_idx] <= addr_gen_wr_data;
    end
    if (upd_i) begin
      i_r[op_ireg] <= agu_bus.upd_val;
    end
  end

  // Modify registers
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int k = 0; k < NUM_ADDR_GEN; k++) begin
        m_r[k] <= `BLS_MREG_RST;
      end
    end else if (addr_gen_wr_en && addr_gen_wr_sel == `BLS_ADDR_GEN_MOD) begin
      m_r[addr_gen_wr_idx] <= addr_gen_wr_data;
    end
  end

  // Load sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go && op_code == OP_LDB) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_rvalid) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      op_ready_r <= (state_nxt == ST_IDLE);
    end
  end

  // Memory request
  always_ff @(posedge clock) begin
    if (rst) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_byte_r <= 1'b0;
      mem_addr_r <= 32'h0;
      mem_wdata_r <= 32'h0;
    end else begin
      mem_req_r <= go && !fault;
      if (go) begin
        mem_we_r <= (op_code != OP_LDB);
        mem_byte_r <= (op_code == OP_LDB);
        mem_addr_r <= agu_bus.ea;
        mem_wdata_r <= src_data;
      end
    end
  end

  // Load write-back with extension
  always_ff @(posedge clock) begin
    if (rst) begin
      ld_sign_r <= 1'b0;
      ld_wb_valid_r <= 1'b0;
      ld_wb_idx_r <= 3'h0;
      ld_wb_data_r <= 32'h0;
    end else begin
      if (go && op_code == OP_LDB) begin
        ld_sign_r <= op_sign;
        ld_wb_idx_r <= op_dreg;
      end
      ld_wb_valid_r <= (state_r == ST_WAIT) && mem_rvalid;
      if (state_r == ST_WAIT && mem_rvalid) begin
        if (ld_sign_r) begin
          ld_wb_data_r <= {{24{mem_rdata[7]}}, mem_rdata};
        end else begin
          ld_wb_data_r <= {24'h0, mem_rdata};
        end
      end
    end
  end

  // Event pulses and readback
  always_ff @(posedge clock) begin
    if (rst) begin
      misalign_exc_r <= 1'b0;
      par_refuse_r <= 1'b0;
      ptr_rd_data_r <= 32'h0;
    end else begin
      misalign_exc_r <= fault;
      par_refuse_r <= refuse;
      ptr_rd_data_r <= p_r[ptr_rd_idx];
    end
  end

  // Checks
  a_sign_extend: assert property (@(posedge clock) disable iff (rst)
    ld_wb_valid_r && ld_sign_r |-> ld_wb_data_r[31:8] == {24{ld_wb_data_r[7]}})
    else $error("signed byte load not sign-extended");

  a_zero_extend: assert property (@(posedge clock) disable iff (rst)
    ld_wb_valid_r && !ld_sign_r |-> ld_wb_data_r[31:8] == 24'h0)
    else $error("unsigned byte load upper bits not clear");

  a_byte_no_fault: assert property (@(posedge clock) disable iff (rst)
    go && op_code == OP_LDB |=> !misalign_exc_r && mem_req_r)
    else $error("byte load faulted or dropped");

  a_byte_postinc: assert property (@(posedge clock) disable iff (rst)
    go && op_code == OP_LDB && op_mode == MD_INC && !ptr_wr_en
    |=> mem_addr_r == $past(p_r[op_preg])
        && p_r[$past(op_preg)] == $past(p_r[op_preg]) + 32'h1)
    else $error("byte post-increment wrong");

  a_byte_postdec: assert property (@(posedge clock) disable iff (rst)
    go && op_code == OP_LDB && op_mode == MD_DEC && !ptr_wr_en
    |=> mem_addr_r == $past(p_r[op_preg])
        && p_r[$past(op_preg)] == $past(p_r[op_preg]) - 32'h1)
    else $error("byte post-decrement wrong");

  a_offset_keeps: assert property (@(posedge clock) disable iff (rst)
    go && op_mode == MD_OFS && !ptr_wr_en |=> p_r[$past(op_preg)] == $past(p_r[op_preg]))
    else $error("offset form changed its pointer");

  a_refuse_keeps: assert property (@(posedge clock) disable iff (rst)
    refuse && !ptr_wr_en |=> p_r[$past(op_preg)] == $past(p_r[op_preg]))
    else $error("refused form changed its pointer");

  a_store_pointer: assert property (@(posedge clock) disable iff (rst)
    go && op_code == OP_STP && !fault |=> mem_wdata_r == $past(p_r[op_src]) && mem_we_r)
    else $error("pointer store data wrong");

  a_wide_refused: assert property (@(posedge clock) disable iff (rst)
    accept && op_insn32 && op_parallel |=> par_refuse_r && !mem_req_r && !misalign_exc_r)
    else $error("wide form issued in parallel was not refused");

  a_store_aligned: assert property (@(posedge clock) disable iff (rst)
    mem_req_r && mem_we_r |-> mem_addr_r[1:0] == 2'h0)
    else $error("misaligned word store reached memory");

  a_fault_no_write: assert property (@(posedge clock) disable iff (rst)
    fault && !ptr_wr_en |=> !mem_req_r && misalign_exc_r
      && p_r[$past(op_preg)] == $past(p_r[op_preg]))
    else $error("faulting store changed memory or pointer");

  a_store_postdec: assert property (@(posedge clock) disable iff (rst)
    go && op_code != OP_LDB && op_mode == MD_DEC && !fault && !ptr_wr_en
    |=> p_r[$past(op_preg)] == $past(p_r[op_preg]) - 32'h4 && mem_we_r)
    else $error("word post-decrement wrong");

  a_store_postinc: assert property (@(posedge clock) disable iff (rst)
    go && op_code != OP_LDB && op_mode == MD_INC && !fault && !ptr_wr_en
    |=> mem_addr_r == $past(p_r[op_preg])
        && p_r[$past(op_preg)] == $past(p_r[op_preg]) + 32'h4)
    else $error("word post-increment wrong");

  a_post_index: assert property (@(posedge clock) disable iff (rst)
    go && op_mode == MD_PIDX && op_preg != op_preg2 && !fault && !ptr_wr_en
    |=> p_r[$past(op_preg)] == $past(p_r[op_preg]) + $past(p_r[op_preg2]))
    else $error("post-index update wrong");

  a_same_pointer: assert property (@(posedge clock) disable iff (rst)
    go && op_mode == MD_PIDX && op_preg == op_preg2 && !ptr_wr_en
    |=> p_r[$past(op_preg)] == $past(p_r[op_preg]))
    else $error("same-pointer post-index updated pointer");

  a_frame_store: assert property (@(posedge clock) disable iff (rst)
    go && op_mode == MD_FRAME && op_code != OP_LDB && !fault
    |=> mem_addr_r == $past(p_r[`BLS_FRAME_PTR_IDX]) - {24'h0, $past(op_imm[7:2]), 2'h0})
    else $error("frame-relative address wrong");

  a_load_returns: assert property (@(posedge clock) disable iff (rst)
    state_r == ST_WAIT && mem_rvalid |=> ld_wb_valid_r && op_ready_r)
    else $error("load result not written back");

  c_byte_load: cover property (@(posedge clock) disable iff (rst)
    go && op_code == OP_LDB ##[1:8] ld_wb_valid_r);
  c_misalign: cover property (@(posedge clock) disable iff (rst) misalign_exc_r);
  c_refuse: cover property (@(posedge clock) disable iff (rst) par_refuse_r);
  c_slow_load: cover property (@(posedge clock) disable iff (rst)
    state_r == ST_WAIT ##1 state_r == ST_WAIT ##1 ld_wb_valid_r);
  c_circ_store: cover property (@(posedge clock) disable iff (rst)
    upd_i && agu_bus.ilen != 32'h0);

endmodule : bls_lsu

`default_nettype wire

// ### bench/bls_mem_model.sv
// Data memory model that answers byte loads after a chosen latency
`default_nettype none

module bls_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Answer latency in cycles, zero answers promptly
  input wire logic [3:0] lat,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_r;
  logic [3:0] cnt_r;
  logic [7:0] byte_r;

  // Byte content is the low address byte with its top bit flipped
  always @(posedge clock) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      pend_r <= 1'b0;
      mem_rdata <= 8'h5a;
    end else if (mem_req && !mem_we && lat == 4'h0) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ 8'h80;
    end else if (mem_req && !mem_we) begin
      pend_r <= 1'b1;
      cnt_r <= lat - 4'h1;
      byte_r <= mem_addr[7:0] ^ 8'h80;
    end else if (pend_r && cnt_r == 4'h0) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= byte_r;
      pend_r <= 1'b0;
    end else if (pend_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule // bls_mem_model

`default_nettype wire

// ### bench/byte_load_word_store_unit_bench.sv
// Self-checking bench for the byte-load / word-store unit
`default_nettype none

module byte_load_word_store_unit_bench
  import bls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, op_valid, op_insn32, op_parallel, op_sign, op_neg;
  bls_op_t op_code;
  bls_mode_t op_mode;
  logic [2:0] op_dreg, op_preg, op_preg2, op_src, ptr_wr_idx, ptr_rd_idx;
  logic [1:0] op_ireg, op_mreg, addr_gen_wr_sel, addr_gen_wr_idx;
  logic [16:0] op_imm;
  logic [31:0] op_store_data, ptr_wr_data, addr_gen_wr_data, ptr_rd_data_r;
  logic ptr_wr_en, addr_gen_wr_en, op_ready_r, mem_req_r, mem_we_r, mem_byte_r;
  logic [31:0] mem_addr_r, mem_wdata_r, ld_wb_data_r;
  logic mem_rvalid, ld_wb_valid_r, misalign_exc_r, par_refuse_r;
  logic [7:0] mem_rdata;
  logic [2:0] ld_wb_idx_r;
  logic [3:0] lat;
  int errors, checked;

  bls_lsu DUT (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_mode(op_mode), .op_insn32(op_insn32), .op_parallel(op_parallel),
    .op_sign(op_sign), .op_neg(op_neg), .op_dreg(op_dreg), .op_preg(op_preg),
    .op_preg2(op_preg2), .op_src(op_src), .op_ireg(op_ireg), .op_mreg(op_mreg),
    .op_imm(op_imm), .op_store_data(op_store_data), .op_ready_r(op_ready_r),
    .ptr_wr_en(ptr_wr_en), .ptr_wr_idx(ptr_wr_idx), .ptr_wr_data(ptr_wr_data),
    .addr_gen_wr_en(addr_gen_wr_en), .addr_gen_wr_sel(addr_gen_wr_sel),
    .addr_gen_wr_idx(addr_gen_wr_idx), .addr_gen_wr_data(addr_gen_wr_data),
    .ptr_rd_idx(ptr_rd_idx), .ptr_rd_data_r(ptr_rd_data_r),
    .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_byte_r(mem_byte_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .ld_wb_valid_r(ld_wb_valid_r), .ld_wb_idx_r(ld_wb_idx_r),
    .ld_wb_data_r(ld_wb_data_r), .misalign_exc_r(misalign_exc_r),
    .par_refuse_r(par_refuse_r));

  bls_mem_model MEM (.clock(clock), .rst(rst), .lat(lat), .mem_req(mem_req_r),
    .mem_we(mem_we_r), .mem_addr(mem_addr_r), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));

  always #5 clock = ~clock;

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wp(input logic [2:0] i, input logic [31:0] v);
    @(posedge clock);
    ptr_wr_en <= 1'b1;
    ptr_wr_idx <= i;
    ptr_wr_data <= v;
    @(posedge clock);
    ptr_wr_en <= 1'b0;
  endtask

  task automatic wd(input logic [1:0] s, input logic [1:0] i, input logic [31:0] v);
    @(posedge clock);
    addr_gen_wr_en <= 1'b1;
    addr_gen_wr_sel <= s;
    addr_gen_wr_idx <= i;
    addr_gen_wr_data <= v;
    @(posedge clock);
    addr_gen_wr_en <= 1'b0;
  endtask

  task automatic rp(input logic [2:0] i, input logic [31:0] x);
    @(posedge clock);
    ptr_rd_idx <= i;
    @(posedge clock);
    #1;
    chk("pointer", x, ptr_rd_data_r);
  endtask

  // Flags f are insn32, parallel, sign, negate; event is wb, refuse, fault, store
  task automatic op(input bls_op_t c, input bls_mode_t m, input logic [3:0] f,
      input logic [2:0] p, input logic [16:0] im, input logic [2:0] q,
      input logic [3:0] ev_x, input logic [31:0] a_x);
    logic [3:0] ev;
    int n;
    ev = 4'h0;
    n = 0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_mode <= m;
    {op_insn32, op_parallel, op_sign, op_neg} <= f;
    op_preg <= p;
    op_ireg <= p[1:0];
    op_mreg <= p[1:0];
    op_imm <= im;
    op_preg2 <= q;
    op_src <= q;
    op_dreg <= q;
    op_store_data <= {16'hc0de, 13'h0, q};
    @(posedge clock);
    // Hold the offer until an edge sees ready high
    while (!op_ready_r && n < 30) begin
      @(posedge clock);
      n++;
    end
    op_valid <= 1'b0;
    #1;
    while (ev == 4'h0 && n < 30) begin
      ev = {ld_wb_valid_r, par_refuse_r, misalign_exc_r, mem_req_r & mem_we_r};
      if (ev == 4'h0) begin
        @(posedge clock);
        #1;
        n++;
      end
    end
    if (n == 30) begin
      errors++;
      results();
    end
    chk("event", {28'h0, ev_x}, {28'h0, ev});
    if (ev_x[3] || ev_x[0])
      chk("address", a_x, mem_addr_r);
  endtask

  task automatic t_reset();
    @(posedge clock);
    #1;
    chk("ready", 32'h1, {31'h0, op_ready_r});
    chk("request", 32'h0, {31'h0, mem_req_r});
    rp(3'h0, 32'h0);
  endtask

  task automatic t_load();
    wp(3'h5, 32'h103);
    wp(3'h0, 32'h8100);
    op(OP_LDB, MD_INC, 4'h2, 3'h5, 17'h0, 3'h3, 4'h8, 32'h103);
    chk("load data", 32'hffffff83, ld_wb_data_r);
    chk("load dest", 32'h3, {29'h0, ld_wb_idx_r});
    chk("byte size", 32'h1, {31'h0, mem_byte_r});
    rp(3'h5, 32'h104);
    op(OP_LDB, MD_DEC, 4'h0, 3'h5, 17'h0, 3'h4, 4'h8, 32'h104);
    chk("load data", 32'h84, ld_wb_data_r);
    rp(3'h5, 32'h103);
    lat <= 4'h3;
    op(OP_LDB, MD_OFS, 4'hb, 3'h0, 17'h7fff, 3'h2, 4'h8, 32'h101);
    chk("load data", 32'hffffff81, ld_wb_data_r);
    rp(3'h0, 32'h8100);
  endtask

  task automatic t_store();
    wp(3'h1, 32'h100);
    wp(3'h2, 32'h8);
    wp(3'h6, 32'h400);
    wp(3'h7, 32'h1000);
    wp(3'h3, 32'h40000);
    op(OP_STD, MD_INC, 4'h0, 3'h1, 17'h0, 3'h0, 4'h1, 32'h100);
    chk("wdata", 32'hc0de0000, mem_wdata_r);
    rp(3'h1, 32'h104);
    op(OP_STP, MD_DEC, 4'h0, 3'h6, 17'h0, 3'h2, 4'h1, 32'h400);
    chk("wdata", 32'h8, mem_wdata_r);
    rp(3'h6, 32'h3fc);
    op(OP_STD, MD_OFS, 4'h0, 3'h1, 17'h3c, 3'h0, 4'h1, 32'h140);
    rp(3'h1, 32'h104);
    op(OP_STD, MD_OFS, 4'h9, 3'h3, 17'h1fffc, 3'h0, 4'h1, 32'h20004);
    op(OP_STP, MD_FRAME, 4'h0, 3'h7, 17'h80, 3'h7, 4'h1, 32'hf80);
    chk("wdata", 32'h1000, mem_wdata_r);
    op(OP_STD, MD_PIDX, 4'h0, 3'h1, 17'h0, 3'h2, 4'h1, 32'h104);
    rp(3'h1, 32'h10c);
    op(OP_STD, MD_PIDX, 4'h0, 3'h1, 17'h0, 3'h1, 4'h1, 32'h10c);
    rp(3'h1, 32'h10c);
  endtask

  task automatic t_fault();
    wp(3'h4, 32'h102);
    op(OP_STD, MD_INC, 4'h0, 3'h4, 17'h0, 3'h0, 4'h2, 32'h0);
    rp(3'h4, 32'h102);
    op(OP_STD, MD_OFS, 4'hc, 3'h1, 17'h4, 3'h0, 4'h4, 32'h0);
    rp(3'h1, 32'h10c);
    op(OP_STD, MD_IND, 4'h4, 3'h1, 17'h0, 3'h0, 4'h1, 32'h10c);
  endtask

  task automatic t_index();
    wd(2'h0, 2'h0, 32'h200);
    wd(2'h3, 2'h0, 32'h200);
    wd(2'h2, 2'h0, 32'h8);
    wd(2'h0, 2'h1, 32'h300);
    wd(2'h1, 2'h1, 32'h10);
    wd(2'h2, 2'h1, 32'h0);
    wd(2'h3, 2'h1, 32'h0);
    op(OP_STD, MD_I_INC, 4'h0, 3'h0, 17'h0, 3'h0, 4'h1, 32'h200);
    op(OP_STD, MD_I_INC, 4'h0, 3'h0, 17'h0, 3'h0, 4'h1, 32'h204);
    op(OP_STD, MD_I_IND, 4'h0, 3'h0, 17'h0, 3'h0, 4'h1, 32'h200);
    op(OP_STD, MD_I_DEC, 4'h0, 3'h0, 17'h0, 3'h0, 4'h1, 32'h200);
    op(OP_STD, MD_I_IND, 4'h0, 3'h0, 17'h0, 3'h0, 4'h1, 32'h204);
    op(OP_STD, MD_I_MOD, 4'h0, 3'h1, 17'h0, 3'h0, 4'h1, 32'h300);
    op(OP_STD, MD_I_IND, 4'h0, 3'h1, 17'h0, 3'h0, 4'h1, 32'h310);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {op_valid, op_insn32, op_parallel, op_sign, op_neg, ptr_wr_en, addr_gen_wr_en} = 7'h0;
    op_code = OP_LDB;
    op_mode = MD_IND;
    {op_dreg, op_preg, op_preg2, op_src, ptr_wr_idx, ptr_rd_idx} = 18'h0;
    {op_ireg, op_mreg, addr_gen_wr_sel, addr_gen_wr_idx} = 8'h0;
    op_imm = 17'h0;
    {op_store_data, ptr_wr_data, addr_gen_wr_data} = 96'h0;
    lat = 4'h0;
    errors = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_store();
    t_fault();
    t_index();
    results();
  end
endmodule // byte_load_word_store_unit_bench

`default_nettype wire
